// ---- rtl/port_pin_levels_defs.svh ----
// register offsets, reset values and control bit positions for the port
`ifndef PORT_PIN_LEVELS_DEFS_SVH
`define PORT_PIN_LEVELS_DEFS_SVH
`define PA_PINS_OFS 12'h000
`define PA_LATCH_OFS 12'h004
`define PA_DIR_OFS 12'h008
`define PA_ANALOG_SELECT_REGISTER_OFS 12'h00C
`define PA_CMPCTL_OFS 12'h010
`define PA_OSCCFG_OFS 12'h014
`define PA_DIR_RST 8'hFF
`define PA_LATCH_RST 8'h00
`define PA_ANALOG_SELECT_REGISTER_RST 5'h1F
`define PA_CMPCTL_RST 4'h0
`define PA_OSC_RST 3'h0
`define PA_CMP1_OE_BIT 0
`define PA_CMP2_OE_BIT 1
`define PA_VREF_OE_BIT 2
`define PA_CMP_OUT_BIT 3
`endif

// ---- rtl/port_pin_levels_pkg.sv ----
// types for the shared-pin port
package port_pin_levels_pkg;
    // oscillator configuration codes, 3 bits
    typedef enum logic [2:0] {
        OSC_XTAL_LP,
        OSC_XTAL_XT,
        OSC_XTAL_HS,
        OSC_RC_CYCLE_CLOCK_OUTPUT,
        OSC_RC_IO,
        OSC_INT_CYCLE_CLOCK_OUTPUT,
        OSC_INT_IO,
        OSC_EXT_IO
    } osc_mode_e;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_state_e;
endpackage

// ---- rtl/pin_sync.sv ----
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage is read only by the second
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ---- rtl/port_pin_levels_gpio.sv ----
// shared-pin 8-bit port with ahb-lite register access
// Contract
// - eight pins, each direction, latch, read
// - direction one disables driver, zero drives
// - pin register reads levels, writes latch
// - latch register reads the driven value
// - pins six, seven read zero unless freed
// - analog select zeroes pins 0-3, 5
// - reset: analog on 0-3,5; pin 4 digital
// - direction still drives analog pins
// - analog mode leaves output path alone
// - comparator output overrides latch, pins 4/5
// - reference output kills pin 2 digital
// - pin six is port only in io modes
// - clock-out modes drive cycle clock pin six
// - pin four feeds timer clock input
// - pin five feeds serial slave select
// - pins 0-5 carry comparator functions
// - enabled peripheral takes pin from port
`timescale 1ns/10ps
`include "port_pin_levels_defs.svh"
module port_pin_levels_gpio (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [7:0] pad_in_i,
    output logic [7:0] pad_out_o,
    output logic [7:0] pad_oe_o,
    input wire logic comparator_one_output_i,
    input wire logic comparator_two_output_i,
    input wire logic cycle_clock_i,
    input wire logic [2:0] osc_config_i,
    output logic timer_external_clock_in_o,
    output logic ssp_slave_select_n_o,
    output logic [4:0] analog_select_bits_o,
    output logic voltage_reference_output_en_o
);
    logic [7:0] dir_q;
    logic [7:0] lat_q;
    logic [4:0] analog_select_register_q;
    logic [3:0] cmpctl_q;
    logic [31:0] rdata_q;
    logic [11:0] addr_q;
    logic wr_pend_q;
    logic [7:0] pin_lvl;
    port_pin_levels_pkg::osc_mode_e osc_mode;

    // two-stage synchroniser on every pad level
    pin_sync #(.WIDTH(8)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pad_in_i),
        .sync_o(pin_lvl)
    );

    // map of analog select bits onto pins 0-3 and 5
    function automatic logic [7:0] analog_pins(input logic [4:0] ans);
        analog_pins = {2'b00, ans[4], 1'b0, ans[3:0]};
    endfunction

    // pin six free for the port only in io modes, pin seven only in OSC_INT_IO and OSC_INT_CYCLE_CLOCK_OUTPUT
    assign osc_mode = port_pin_levels_pkg::osc_mode_e'(osc_config_i);
    wire pin6_io = (osc_mode == port_pin_levels_pkg::OSC_RC_IO) ||
        (osc_mode == port_pin_levels_pkg::OSC_INT_IO) ||
        (osc_mode == port_pin_levels_pkg::OSC_EXT_IO);
    wire pin7_io = (osc_mode == port_pin_levels_pkg::OSC_INT_IO) ||
        (osc_mode == port_pin_levels_pkg::OSC_INT_CYCLE_CLOCK_OUTPUT);
    wire cycle_clock_output_mode = (osc_mode == port_pin_levels_pkg::OSC_RC_CYCLE_CLOCK_OUTPUT) ||
        (osc_mode == port_pin_levels_pkg::OSC_INT_CYCLE_CLOCK_OUTPUT);
    wire [7:0] io_mask = {pin7_io, pin6_io, 6'h3F};

    // peripheral enables taking pins from the port
    wire cmp1_oe = cmpctl_q[`PA_CMP1_OE_BIT];
    wire cmp2_oe = cmpctl_q[`PA_CMP2_OE_BIT];
    wire vref_oe = cmpctl_q[`PA_VREF_OE_BIT];
    wire [7:0] ana_mask = analog_pins(analog_select_register_q);

    // digital input path: analog or reference pins read zero
    wire [7:0] in_kill = ana_mask | {5'h00, vref_oe, 2'b00};
    wire [7:0] pin_read = pin_lvl & ~in_kill & io_mask;
    wire [7:0] dir_read = dir_q & io_mask;
    wire [7:0] lat_read = lat_q & io_mask;

    // output data: comparators override latch on pins 4 and 5
    wire [7:0] out_data = {lat_q[7],
        cycle_clock_output_mode ? cycle_clock_i : lat_q[6],
        cmp2_oe ? comparator_two_output_i : lat_q[5],
        cmp1_oe ? comparator_one_output_i : lat_q[4],
        lat_q[3:0]};

    // output enables: direction zero drives, analog mode ignored
    wire [7:0] drv_base = ~dir_q & io_mask;
    wire [7:0] drv_en = {drv_base[7],
        drv_base[6] | cycle_clock_output_mode,
        drv_base[5:3], drv_base[2] & ~vref_oe, drv_base[1:0]};

    assign pad_out_o = out_data;
    assign pad_oe_o = drv_en;

    // alternate digital inputs fed from synchronised levels
    assign timer_external_clock_in_o = pin_lvl[4];
    assign ssp_slave_select_n_o = pin_lvl[5] | ana_mask[5];
    assign analog_select_bits_o = analog_select_register_q;
    assign voltage_reference_output_en_o = vref_oe;

    // ahb-lite address phase decode
    wire take = hsel_i && hready_i && htrans_i[1];
    wire do_wr = take && hwrite_i;
    wire [11:0] rd_addr = haddr_i;

    // read mux, zero on unmapped offsets
    wire [31:0] rd_mux =
        (rd_addr == `PA_PINS_OFS) ? {24'h0, pin_read} :
        (rd_addr == `PA_LATCH_OFS) ? {24'h0, lat_read} :
        (rd_addr == `PA_DIR_OFS) ? {24'h0, dir_read} :
        (rd_addr == `PA_ANALOG_SELECT_REGISTER_OFS) ? {27'h0, analog_select_register_q} :
        (rd_addr == `PA_CMPCTL_OFS) ?
            {28'h0, comparator_one_output_i, cmpctl_q[2:0]} :
        (rd_addr == `PA_OSCCFG_OFS) ? {29'h0, osc_config_i} : 32'h0;

    // bus phase tracking and read data register
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
            rdata_q <= 32'h0;
        end
        else
        begin
            wr_pend_q <= do_wr;
            if (take)
            begin
                addr_q <= haddr_i;
            end
            if (take && !hwrite_i)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    // data phase write decode
    wire wr_pins = wr_pend_q && (addr_q == `PA_PINS_OFS);
    wire wr_lat = wr_pend_q && (addr_q == `PA_LATCH_OFS);
    wire wr_dir = wr_pend_q && (addr_q == `PA_DIR_OFS);
    wire wr_ans = wr_pend_q && (addr_q == `PA_ANALOG_SELECT_REGISTER_OFS);
    wire wr_cmp = wr_pend_q && (addr_q == `PA_CMPCTL_OFS);

    // control registers, written in the data phase
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            dir_q <= `PA_DIR_RST;
            lat_q <= `PA_LATCH_RST;
            analog_select_register_q <= `PA_ANALOG_SELECT_REGISTER_RST;
            cmpctl_q <= `PA_CMPCTL_RST;
        end
        else
        begin
            if (wr_pins || wr_lat)
            begin
                lat_q <= hwdata_i[7:0];
            end
            if (wr_dir)
            begin
                dir_q <= hwdata_i[7:0];
            end
            if (wr_ans)
            begin
                analog_select_register_q <= hwdata_i[4:0];
            end
            if (wr_cmp)
            begin
                cmpctl_q <= hwdata_i[3:0];
            end
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // reset sets every direction bit to one, so pins are undriven except pin six in clock-out modes
    property p_reset_no_drive;
        @(posedge sys_clk_i) !rst_n_i |=> (dir_q == 8'hFF);
    endproperty
    a_reset_no_drive: assert property (p_reset_no_drive)
        else $error("direction not input after reset");

    // analog pins read zero through the pin register
    property p_analog_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (pin_read & ana_mask) == 8'h00;
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read non-zero");

    // direction zero drives, analog mode notwithstanding
    property p_dir_drive;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!dir_q[0]) |-> pad_oe_o[0] && pad_out_o[0] == lat_q[0];
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("pin 0 not driving latch");

    // reference output blocks pin two both ways
    property p_vref;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        vref_oe |-> !pad_oe_o[2] && !pin_read[2];
    endproperty
    a_vref: assert property (p_vref)
        else $error("pin 2 digital with reference on");

    // comparator one overrides latch on pin four
    property p_cmp1;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cmp1_oe && !dir_q[4] |-> pad_out_o[4] == comparator_one_output_i;
    endproperty
    a_cmp1: assert property (p_cmp1)
        else $error("comparator not on pin 4");

    // pin six and its bits read zero unless freed
    property p_hi_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !pin6_io |-> !dir_read[6] && !lat_read[6] && !pin_read[6];
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("pin 6 bits visible in oscillator mode");

    // clock-out on pin six regardless of direction
    property p_cycle_clock_output;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_clock_output_mode |-> pad_oe_o[6] && pad_out_o[6] == cycle_clock_i;
    endproperty
    a_cycle_clock_output: assert property (p_cycle_clock_output)
        else $error("cycle clock missing on pin 6");

    // latch write reaches pad two edges after address phase
    sequence s_lat_wr;
        take && hwrite_i && haddr_i == `PA_LATCH_OFS;
    endsequence
    property p_lat_wr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_lat_wr ##1 1'b1 |=> lat_q == $past(hwdata_i[7:0]);
    endproperty
    a_lat_wr: assert property (p_lat_wr)
        else $error("latch write lost");

    // pin level visible two edges later on the timer input
    property p_sync;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rst_n_i ##2 1'b1 |->
            timer_external_clock_in_o == $past(pad_in_i[4], 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("pin 4 synchroniser depth wrong");

    // comparator two overrides latch on pin five
    property p_cmp2;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cmp2_oe && !dir_q[5] |-> pad_out_o[5] == comparator_two_output_i;
    endproperty
    a_cmp2: assert property (p_cmp2)
        else $error("comparator not on pin 5");

    // analog pin five holds the slave select inactive
    property p_ss_analog;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ana_mask[5] |-> ssp_slave_select_n_o;
    endproperty
    a_ss_analog: assert property (p_ss_analog)
        else $error("slave select active on analog pin");

    // pin seven and its bits read zero unless freed
    property p_pin7_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !pin7_io |-> !dir_read[7] && !lat_read[7] && !pin_read[7];
    endproperty
    a_pin7_zero: assert property (p_pin7_zero)
        else $error("pin 7 bits visible in oscillator mode");

    // analog select leaves the output path of pin three alone
    property p_analog_drive;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        analog_select_register_q[3] && !dir_q[3] |-> pad_oe_o[3] && pad_out_o[3] == lat_q[3];
    endproperty
    a_analog_drive: assert property (p_analog_drive)
        else $error("analog pin 3 not driving latch");

    // reset puts latch and analog select at their defaults
    property p_reset_defaults;
        @(posedge sys_clk_i)
        !rst_n_i |=> lat_q == `PA_LATCH_RST && analog_select_register_q == `PA_ANALOG_SELECT_REGISTER_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("latch or analog select wrong after reset");

    // latch read returns the driven value in the data phase
    sequence s_lat_rd;
        take && !hwrite_i && haddr_i == `PA_LATCH_OFS;
    endsequence
    property p_lat_rd;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_lat_rd |=> hrdata_o == {24'h0, $past(lat_read)};
    endproperty
    a_lat_rd: assert property (p_lat_rd)
        else $error("latch read not the driven value");
endmodule

// ---- bench/board_pins.sv ----
// board model of the signals on the eight port pins
`timescale 1ns/10ps
module board_pins (
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] drive_i,
    output logic [7:0] pad_in_o
);
    // a driven pin shows the device value, else the board level
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & drive_i);
endmodule

// ---- bench/port_a_gpio_with_pin_sharing_bench.sv ----
// self-checking bench for the shared-pin port
`timescale 1ns/10ps
module port_a_gpio_with_pin_sharing_bench;
    logic clk, rst_n, hsel, hwrite, hready, hresp, cmp1, cmp2, cyc, tmr;
    logic ss_n, vref_en;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, osc;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] pad_in, pad_out, pad_oe, board;
    logic [4:0] ans;
    int fail_count = 0;
    int check_count = 0;
    port_pin_levels_gpio DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .comparator_one_output_i(cmp1), .comparator_two_output_i(cmp2),
        .cycle_clock_i(cyc), .osc_config_i(osc),
        .timer_external_clock_in_o(tmr), .ssp_slave_select_n_o(ss_n),
        .analog_select_bits_o(ans), .voltage_reference_output_en_o(vref_en));
    board_pins board_u (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .drive_i(board), .pad_in_o(pad_in));
    // clock and cycle-clock stand-in
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= (cyc !== 1'b1);
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // wait for hready at a rising edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
    endtask
    // one single-word ahb-lite transfer
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        #1;
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(what, rd, exp);
    endtask
    // let pad levels pass the two-stage synchroniser
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set_board(input logic [7:0] v);
        @(posedge clk);
        board <= v;
        settle();
    endtask
    task automatic t_reset();
        rdchk("dir", 12'h008, 32'h000000FF);
        rdchk("latch", 12'h004, 32'h00000000);
        rdchk("analog_select_register", 12'h00C, 32'h0000001F);
        rdchk("ctl", 12'h010, 32'h00000000);
        rdchk("pins", 12'h000, 32'h000000D0);
        check("oe", pad_oe, 8'h00);
        check("resp", hresp, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_latch_drive();
        bus(12'h000, 1'b1, 32'h000000A5);
        rdchk("latch", 12'h004, 32'h000000A5);
        rdchk("pins", 12'h000, 32'h000000D0);
        bus(12'h008, 1'b1, 32'h00000000);
        check("oe", pad_oe, 8'hFF);
        check("out", pad_out, 8'hA5);
        settle();
        rdchk("pins drv", 12'h000, 32'h00000080);
        $display("test latch done");
    endtask
    task automatic t_comparator();
        cmp1 <= 1'b1;
        cmp2 <= 1'b0;
        bus(12'h010, 1'b1, 32'h00000003);
        check("cmp out", pad_out[5:4], 2'b01);
        rdchk("ctl", 12'h010, 32'h0000000B);
        bus(12'h010, 1'b1, 32'h00000004);
        check("vref oe", pad_oe[2], 1'b0);
        check("vref en", vref_en, 1'b1);
        bus(12'h00C, 1'b1, 32'h00000000);
        bus(12'h008, 1'b1, 32'h000000FF);
        settle();
        rdchk("vref in", 12'h000, 32'h000000FB);
        bus(12'h010, 1'b1, 32'h00000000);
        $display("test comparator done");
    endtask
    task automatic t_digital_in();
        set_board(8'h3C);
        rdchk("pins", 12'h000, 32'h0000003C);
        check("tmr", tmr, 1'b1);
        check("ss", ss_n, 1'b1);
        set_board(8'h0C);
        check("tmr lo", tmr, 1'b0);
        check("ss lo", ss_n, 1'b0);
        bus(12'h00C, 1'b1, 32'h00000010);
        check("ans", ans, 5'h10);
        set_board(8'h20);
        rdchk("pin5 an", 12'h000, 32'h00000000);
        set_board(8'h00);
        check("ss an", ss_n, 1'b1);
        rdchk("unmapped", 12'h020, 32'h00000000);
        $display("test digital in done");
    endtask
    task automatic t_osc();
        logic p6, p7;
        for (int m = 0; m < 8; m++)
        begin
            osc <= m[2:0];
            p6 = (m == 4 || m == 6 || m == 7);
            p7 = (m == 5 || m == 6);
            bus(12'h008, 1'b1, 32'h000000FF);
            rdchk("dir", 12'h008, {24'h0, p7, p6, 6'h3F});
            rdchk("osc", 12'h014, {29'h0, m[2:0]});
            check("oe6", pad_oe[6], m == 3 || m == 5);
            if (m == 3 || m == 5)
                check("cycle_clock_output", pad_out[6], cyc);
        end
        $display("test osc done");
    endtask
    initial
    begin
        rst_n = 0;
        hsel = 0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cmp1 = 0;
        cmp2 = 0;
        osc = 3'h6;
        board = 8'hFF;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_latch_drive();
        t_comparator();
        t_digital_in();
        t_osc();
        conclude();
    end
endmodule
